// ==== logic/dppa_defines.svh ====
`ifndef DPPA_DEFINES_SVH
`define DPPA_DEFINES_SVH
// Function
// - select lines 00/01 reach A port, direction, control
// - select lines 10/11 reach B port, direction, control
// - B port read returns register for outputs
// - separate open-drain low interrupt per side
// - A edge sets bit 7, bit 0 gates
// - A line edge sets bit 6, bit 3 gates
// - reading A port clears A flags
// - B flags set and gated like A
// - reading B port clears B flags
// - direction bit one means output line
// - B input lines leave driver off
// - bit 1 picks A edge polarity
// - bit 5 low makes A line input
// - A pulse mode pulses on port read
// - A handshake: edge in, read drops line
// - bits 5,4 high: line follows bit 3
// - B edge input behaves like A's
// - B line input modes match A's
// - B pulse triggers on port write
// - B handshake: write strobes, edge acknowledges
// - bit 4 picks line edge, bit 3 enables
// - A handshake edge raises, read lowers line
// - B handshake write lowers, edge raises line
// - pulse mode holds line low one cycle
`define DPPA_REG_RST 8'h00
`define DPPA_CR_EDGE_EN 0
`define DPPA_CR_EDGE_POL 1
`define DPPA_CR_PORT_SEL 2
`define DPPA_CR_LINE_B3 3
`define DPPA_CR_LINE_POL 4
`define DPPA_CR_LINE_OUT 5
`define DPPA_MODE_HSHAKE 3'h4
`define DPPA_MODE_PULSE 3'h5
`define DPPA_RS_PORT_A 2'h0
`define DPPA_RS_CTL_A 2'h1
`define DPPA_RS_PORT_B 2'h2
`define DPPA_RS_CTL_B 2'h3
`endif

// ==== logic/dppa_pkg.sv ====
`include "dppa_defines.svh"
package dppa_pkg;
    typedef enum logic [2:0] {
        SEL_PORT_A,
        SEL_DIR_A,
        SEL_CTL_A,
        SEL_PORT_B,
        SEL_DIR_B,
        SEL_CTL_B
    } dppa_sel_t;

    typedef struct packed {
        logic phase2;
        logic cs1;
        logic cs2;
        logic cs3_n;
        logic sel_hi;
        logic sel_lo;
        logic rnw;
        logic [7:0] data;
        logic [7:0] pa;
        logic [7:0] pb;
        logic a_edge;
        logic a_line;
        logic b_edge;
        logic b_line;
    } dppa_pins_t;

    typedef struct packed {
        logic [5:0] cr;
        logic flag_edge;
        logic flag_line;
        logic edge_prev;
        logic line_prev;
        logic line_out;
        logic irq_act;
    } dppa_side_t;

    typedef struct packed {
        dppa_pins_t pins_s1;
        dppa_pins_t pins_s2;
        logic phase_prev;
        logic cyc_cs;
        logic cyc_hi;
        logic cyc_lo;
        logic cyc_rnw;
        logic [7:0] cyc_data;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] data_a;
        logic [7:0] data_b;
        logic [7:0] bus_out;
        logic bus_oe;
        logic irq_lvl;
    } dppa_top_t;

    function automatic dppa_sel_t dppa_decode(input logic hi, input logic lo,
                                              input logic a_port, input logic b_port);
        dppa_sel_t s;
        s = SEL_CTL_B;
        unique case ({hi, lo})
            `DPPA_RS_PORT_A: s = a_port ? SEL_PORT_A : SEL_DIR_A;
            `DPPA_RS_CTL_A: s = SEL_CTL_A;
            `DPPA_RS_PORT_B: s = b_port ? SEL_PORT_B : SEL_DIR_B;
            `DPPA_RS_CTL_B: s = SEL_CTL_B;
        endcase
        return s;
    endfunction
endpackage

// ==== logic/dppa_ctl_side.sv ====
`timescale 1ns/100ps
`include "dppa_defines.svh"
module dppa_ctl_side #(
    parameter bit TRIG_ON_WRITE = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic edge_in_i,
    input wire logic line_in_i,
    input wire logic ctl_wr_i,
    input wire logic [7:0] ctl_wdata_i,
    input wire logic port_rd_i,
    input wire logic port_wr_i,
    output logic [7:0] ctl_o,
    output logic line_o,
    output logic line_oe_o,
    output logic irq_act_o
);
    dppa_pkg::dppa_side_t st_reg;
    dppa_pkg::dppa_side_t st_next;
    logic edge_hit;
    logic line_hit;
    logic trig;

    // inputs here are already synchronised by the top
    assign edge_hit = st_reg.cr[`DPPA_CR_EDGE_POL] ? (edge_in_i & ~st_reg.edge_prev)
                                                   : (~edge_in_i & st_reg.edge_prev);
    assign line_hit = ~st_reg.cr[`DPPA_CR_LINE_OUT] &
                      (st_reg.cr[`DPPA_CR_LINE_POL] ? (line_in_i & ~st_reg.line_prev)
                                                    : (~line_in_i & st_reg.line_prev));
    assign trig = TRIG_ON_WRITE ? port_wr_i : port_rd_i;

    always_comb begin
        st_next = st_reg;
        st_next.edge_prev = edge_in_i;
        st_next.line_prev = line_in_i;
        if (ctl_wr_i) begin
            st_next.cr = ctl_wdata_i[5:0];
        end
        // a new edge wins over the clearing read in the same cycle
        st_next.flag_edge = edge_hit | (st_reg.flag_edge & ~port_rd_i);
        st_next.flag_line = line_hit | (st_reg.flag_line & ~port_rd_i);
        if (!st_reg.cr[`DPPA_CR_LINE_OUT]) begin
            st_next.line_out = 1'b1;
        end else if (st_reg.cr[`DPPA_CR_LINE_POL]) begin
            st_next.line_out = st_reg.cr[`DPPA_CR_LINE_B3];
        end else if (st_reg.cr[`DPPA_CR_LINE_B3]) begin
            st_next.line_out = ~trig;
        end else if (edge_hit) begin
            // peripheral edge beats a same-cycle access so the handshake cannot stall
            st_next.line_out = 1'b1;
        end else if (trig) begin
            st_next.line_out = 1'b0;
        end
        st_next.irq_act = (st_next.flag_edge & st_next.cr[`DPPA_CR_EDGE_EN]) |
                          (st_next.flag_line & st_next.cr[`DPPA_CR_LINE_B3]);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
            st_reg.line_out <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ctl_o = {st_reg.flag_edge, st_reg.flag_line, st_reg.cr};
    assign line_o = st_reg.line_out;
    assign line_oe_o = st_reg.cr[`DPPA_CR_LINE_OUT];
    assign irq_act_o = st_reg.irq_act;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    edge_flag_set_a: assert property (edge_hit |=> st_reg.flag_edge)
        else $error("edge flag not set after active edge");
    line_flag_set_a: assert property (line_hit |=> st_reg.flag_line)
        else $error("line flag not set after active edge");
    read_clear_a: assert property (port_rd_i && !edge_hit && !line_hit |=>
        !st_reg.flag_edge && !st_reg.flag_line)
        else $error("port read did not clear flags");
    irq_gate_a: assert property (st_reg.irq_act |->
        (st_reg.flag_edge && st_reg.cr[0]) || (st_reg.flag_line && st_reg.cr[3]))
        else $error("interrupt without enabled flag");
    pulse_width_a: assert property (st_reg.cr[5:3] == `DPPA_MODE_PULSE && trig && !ctl_wr_i
        |=> !st_reg.line_out ##1 (st_reg.line_out || trig && $past(trig) == 1'b0))
        else $error("pulse not exactly one cycle low");
    hshake_rise_a: assert property (st_reg.cr[5:3] == `DPPA_MODE_HSHAKE && edge_hit
        && !ctl_wr_i |=> st_reg.line_out)
        else $error("handshake line not raised by edge");
    manual_level_a: assert property (st_reg.cr[5:4] == 2'h3 |=>
        st_reg.line_out == $past(st_reg.cr[3]))
        else $error("manual line level wrong");
endmodule // dppa_ctl_side

// ==== logic/dppa_top.sv ====
`timescale 1ns/100ps
`include "dppa_defines.svh"
module dppa_top (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic phase2_i,
    input wire logic chip_sel1_i,
    input wire logic chip_sel2_i,
    input wire logic chip_sel3_n_i,
    input wire logic select_low_i,
    input wire logic select_high_i,
    input wire logic read_not_write_i,
    input wire logic [7:0] bus_data_i,
    output logic [7:0] bus_data_o,
    output logic bus_data_oe_o,
    input wire logic [7:0] a_port_pins_i,
    output logic [7:0] a_port_pins_o,
    output logic [7:0] a_port_pins_oe_o,
    input wire logic [7:0] b_port_pins_i,
    output logic [7:0] b_port_pins_o,
    output logic [7:0] b_port_pins_oe_o,
    input wire logic a_edge_input_i,
    input wire logic b_edge_input_i,
    input wire logic a_control_line_i,
    output logic a_control_line_o,
    output logic a_control_line_oe_o,
    input wire logic b_control_line_i,
    output logic b_control_line_o,
    output logic b_control_line_oe_o,
    input wire logic a_interrupt_request_n_i,
    output logic a_interrupt_request_n_o,
    output logic a_interrupt_request_n_oe_o,
    input wire logic b_interrupt_request_n_i,
    output logic b_interrupt_request_n_o,
    output logic b_interrupt_request_n_oe_o
);
    dppa_pkg::dppa_top_t st_reg;
    dppa_pkg::dppa_top_t st_next;
    dppa_pkg::dppa_pins_t pins_raw;
    dppa_pkg::dppa_sel_t rd_sel;
    dppa_pkg::dppa_sel_t cm_sel;
    logic [7:0] a_cr;
    logic [7:0] b_cr;
    logic [7:0] a_view;
    logic [7:0] b_view;
    logic [7:0] rd_val;
    logic cs_now;
    logic rd_now;
    logic commit;
    logic cm_rd;
    logic cm_wr;
    logic a_port_rd;
    logic b_port_rd;
    logic b_port_wr;
    logic a_ctl_wr;
    logic b_ctl_wr;

    // every pin, bus strobes included, crosses two flops before use
    assign pins_raw.phase2 = phase2_i;
    assign pins_raw.cs1 = chip_sel1_i;
    assign pins_raw.cs2 = chip_sel2_i;
    assign pins_raw.cs3_n = chip_sel3_n_i;
    assign pins_raw.sel_hi = select_high_i;
    assign pins_raw.sel_lo = select_low_i;
    assign pins_raw.rnw = read_not_write_i;
    assign pins_raw.data = bus_data_i;
    assign pins_raw.pa = a_port_pins_i;
    assign pins_raw.pb = b_port_pins_i;
    assign pins_raw.a_edge = a_edge_input_i;
    assign pins_raw.a_line = a_control_line_i;
    assign pins_raw.b_edge = b_edge_input_i;
    assign pins_raw.b_line = b_control_line_i;

    assign cs_now = st_reg.pins_s2.cs1 & st_reg.pins_s2.cs2 & ~st_reg.pins_s2.cs3_n;
    assign rd_now = st_reg.pins_s2.phase2 & cs_now & st_reg.pins_s2.rnw;

    // access takes effect on the trailing edge of the phase-two strobe
    assign commit = st_reg.phase_prev & ~st_reg.pins_s2.phase2 & st_reg.cyc_cs;
    assign cm_rd = commit & st_reg.cyc_rnw;
    assign cm_wr = commit & ~st_reg.cyc_rnw;

    assign rd_sel = dppa_pkg::dppa_decode(st_reg.pins_s2.sel_hi, st_reg.pins_s2.sel_lo,
                                          a_cr[`DPPA_CR_PORT_SEL],
                                          b_cr[`DPPA_CR_PORT_SEL]);
    assign cm_sel = dppa_pkg::dppa_decode(st_reg.cyc_hi, st_reg.cyc_lo,
                                          a_cr[`DPPA_CR_PORT_SEL],
                                          b_cr[`DPPA_CR_PORT_SEL]);

    assign a_port_rd = cm_rd & (cm_sel == dppa_pkg::SEL_PORT_A);
    assign b_port_rd = cm_rd & (cm_sel == dppa_pkg::SEL_PORT_B);
    assign b_port_wr = cm_wr & (cm_sel == dppa_pkg::SEL_PORT_B);
    assign a_ctl_wr = cm_wr & (cm_sel == dppa_pkg::SEL_CTL_A);
    assign b_ctl_wr = cm_wr & (cm_sel == dppa_pkg::SEL_CTL_B);

    // A reads pins even on outputs, so a loaded output can read back wrong
    assign a_view = st_reg.pins_s2.pa;
    // B outputs read from the register, immune to heavy loads
    assign b_view = (st_reg.data_b & st_reg.dir_b) |
                    (st_reg.pins_s2.pb & ~st_reg.dir_b);

    always_comb begin
        rd_val = `DPPA_REG_RST;
        unique case (rd_sel)
            dppa_pkg::SEL_PORT_A: rd_val = a_view;
            dppa_pkg::SEL_DIR_A: rd_val = st_reg.dir_a;
            dppa_pkg::SEL_CTL_A: rd_val = a_cr;
            dppa_pkg::SEL_PORT_B: rd_val = b_view;
            dppa_pkg::SEL_DIR_B: rd_val = st_reg.dir_b;
            dppa_pkg::SEL_CTL_B: rd_val = b_cr;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.pins_s1 = pins_raw;
        st_next.pins_s2 = st_reg.pins_s1;
        st_next.phase_prev = st_reg.pins_s2.phase2;
        st_next.irq_lvl = 1'b0;
        if (st_reg.pins_s2.phase2) begin
            st_next.cyc_cs = cs_now;
            st_next.cyc_hi = st_reg.pins_s2.sel_hi;
            st_next.cyc_lo = st_reg.pins_s2.sel_lo;
            st_next.cyc_rnw = st_reg.pins_s2.rnw;
            st_next.cyc_data = st_reg.pins_s2.data;
        end
        st_next.bus_oe = rd_now;
        if (rd_now) begin
            st_next.bus_out = rd_val;
        end
        if (cm_wr) begin
            unique case (cm_sel)
                dppa_pkg::SEL_PORT_A: st_next.data_a = st_reg.cyc_data;
                dppa_pkg::SEL_DIR_A: st_next.dir_a = st_reg.cyc_data;
                dppa_pkg::SEL_PORT_B: st_next.data_b = st_reg.cyc_data;
                dppa_pkg::SEL_DIR_B: st_next.dir_b = st_reg.cyc_data;
                dppa_pkg::SEL_CTL_A: st_next.irq_lvl = 1'b0;
                dppa_pkg::SEL_CTL_B: st_next.irq_lvl = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    dppa_ctl_side #(
        .TRIG_ON_WRITE(1'b0)
    ) u_side_a (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .edge_in_i(st_reg.pins_s2.a_edge),
        .line_in_i(st_reg.pins_s2.a_line),
        .ctl_wr_i(a_ctl_wr),
        .ctl_wdata_i(st_reg.cyc_data),
        .port_rd_i(a_port_rd),
        .port_wr_i(1'b0),
        .ctl_o(a_cr),
        .line_o(a_control_line_o),
        .line_oe_o(a_control_line_oe_o),
        .irq_act_o(a_interrupt_request_n_oe_o)
    );

    // B pulses and handshakes on a port write rather than a read
    dppa_ctl_side #(
        .TRIG_ON_WRITE(1'b1)
    ) u_side_b (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .edge_in_i(st_reg.pins_s2.b_edge),
        .line_in_i(st_reg.pins_s2.b_line),
        .ctl_wr_i(b_ctl_wr),
        .ctl_wdata_i(st_reg.cyc_data),
        .port_rd_i(b_port_rd),
        .port_wr_i(b_port_wr),
        .ctl_o(b_cr),
        .line_o(b_control_line_o),
        .line_oe_o(b_control_line_oe_o),
        .irq_act_o(b_interrupt_request_n_oe_o)
    );

    assign bus_data_o = st_reg.bus_out;
    assign bus_data_oe_o = st_reg.bus_oe;
    assign a_port_pins_o = st_reg.data_a;
    assign a_port_pins_oe_o = st_reg.dir_a;
    assign b_port_pins_o = st_reg.data_b;
    assign b_port_pins_oe_o = st_reg.dir_b;
    // open drain: level is always low, the enable carries the request
    assign a_interrupt_request_n_o = st_reg.irq_lvl;
    assign b_interrupt_request_n_o = st_reg.irq_lvl;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    dir_write_a: assert property (cm_wr && cm_sel == dppa_pkg::SEL_DIR_A |=>
        a_port_pins_oe_o == $past(st_reg.cyc_data))
        else $error("direction write not on port enables");
    b_off_a: assert property (cm_wr && cm_sel == dppa_pkg::SEL_DIR_B |=>
        (b_port_pins_oe_o | $past(st_reg.cyc_data)) == $past(st_reg.cyc_data))
        else $error("B input line still driven");
    b_readback_a: assert property (rd_now && rd_sel == dppa_pkg::SEL_PORT_B |=>
        bus_data_o == $past(b_view) && bus_data_oe_o)
        else $error("B port read value wrong");
    a_readback_a: assert property (rd_now && rd_sel == dppa_pkg::SEL_PORT_A |=>
        bus_data_o == $past(st_reg.pins_s2.pa))
        else $error("A port read not pin level");
    ctl_b_write_a: assert property (b_ctl_wr |=> b_cr[5:0] == $past(st_reg.cyc_data[5:0]))
        else $error("B control write lost");
    bus_quiet_a: assert property (!rd_now |=> !bus_data_oe_o)
        else $error("data bus driven without read");
    a_pulse_read_a: assert property (a_port_rd && a_cr[5:3] == `DPPA_MODE_PULSE
        && !a_ctl_wr |=> !a_control_line_o ##1 a_control_line_o)
        else $error("A pulse missing after port read");
    b_hshake_write_a: assert property (b_port_wr && b_cr[5:3] == `DPPA_MODE_HSHAKE
        && !$rose(st_reg.pins_s2.b_edge) && !$fell(st_reg.pins_s2.b_edge)
        |=> !b_control_line_o)
        else $error("B handshake line not lowered by write");
    irq_pin_a: assert property (a_interrupt_request_n_oe_o |->
        (a_cr[7] && a_cr[0]) || (a_cr[6] && a_cr[3]))
        else $error("A request without enabled flag");
endmodule // dppa_top

// ==== sim/dppa_periph_model.sv ====
`timescale 1ns/100ps
module dppa_periph_model (
    input wire logic core_clk_i,
    input wire logic load_i,
    input wire logic [7:0] a_drv_i,
    input wire logic [7:0] a_drv_oe_i,
    input wire logic [7:0] a_ext_i,
    output logic [7:0] a_pins_o,
    input wire logic [7:0] b_drv_i,
    input wire logic [7:0] b_drv_oe_i,
    input wire logic [7:0] b_ext_i,
    output logic [7:0] b_pins_o,
    input wire logic a_line_drv_i,
    input wire logic a_line_oe_i,
    input wire logic a_line_ext_i,
    output logic a_line_o,
    input wire logic b_line_drv_i,
    input wire logic b_line_oe_i,
    input wire logic b_line_ext_i,
    output logic b_line_o,
    input wire logic a_irq_oe_i,
    input wire logic b_irq_oe_i,
    output logic a_irq_n_o,
    output logic b_irq_n_o,
    input wire logic b_edge_req_i,
    output logic b_edge_o
);
    logic [3:0] ack_cnt;
    logic b_line_q;
    // peripheral drives only the lines the port leaves as inputs
    // load_i drags A line 7 and B line 1 low, as a heavy load on a driven output would
    assign a_pins_o = ((a_drv_oe_i & a_drv_i) | (~a_drv_oe_i & a_ext_i)) &
                      ~{load_i, 7'h00};
    assign b_pins_o = ((b_drv_oe_i & b_drv_i) | (~b_drv_oe_i & b_ext_i)) &
                      ~{6'h00, load_i, 1'h0};
    assign a_line_o = a_line_oe_i ? a_line_drv_i : a_line_ext_i;
    assign b_line_o = b_line_oe_i ? b_line_drv_i : b_line_ext_i;
    // open drain with pull-up, so the request wire idles high
    assign a_irq_n_o = ~a_irq_oe_i;
    assign b_irq_n_o = ~b_irq_oe_i;
    // acknowledge as a three-cycle low pulse, late enough for the strobe to be seen
    assign b_edge_o = b_edge_req_i & ~(ack_cnt inside {[4'h5:4'h7]});
    initial begin
        ack_cnt = 4'h0;
        b_line_q = 1'b1;
    end
    always @(posedge core_clk_i) begin
        b_line_q <= b_line_o;
        if (b_line_oe_i && b_line_q && !b_line_o) begin
            ack_cnt <= 4'h1;
        end else if (ack_cnt != 4'h0) begin
            ack_cnt <= ack_cnt + 4'h1;
        end
    end
endmodule // dppa_periph_model

// ==== sim/dppa_tb_top.sv ====
`timescale 1ns/100ps
`include "dppa_defines.svh"
module dual_port_peripheral_adapter_tb_top;
    localparam logic [1:0] P_A = `DPPA_RS_PORT_A;
    localparam logic [1:0] C_A = `DPPA_RS_CTL_A;
    localparam logic [1:0] P_B = `DPPA_RS_PORT_B;
    localparam logic [1:0] C_B = `DPPA_RS_CTL_B;
    logic clk, rst_b, ph2, cs1, cs3_n, rs_hi, rs_lo, rnw, a_line_ext, b_line_ext, a_edge, b_edge_req;
    logic [7:0] host_d, a_ext, b_ext, d_o, a_po, a_poe, b_po, b_poe, a_pins, b_pins, junk;
    logic d_oe, a_lo, a_loe, b_lo, b_loe, a_iroe, b_iroe, a_line, b_line, a_irq_n, b_irq_n, b_edge;
    logic load;
    int miscompares, n_compared, cycles, a_lows, b_lows;

    dppa_top u_dppa_top (.core_clk_i(clk), .rst_b_i(rst_b), .phase2_i(ph2), .chip_sel1_i(cs1),
        .chip_sel2_i(1'b1), .chip_sel3_n_i(cs3_n), .select_low_i(rs_lo), .select_high_i(rs_hi),
        .read_not_write_i(rnw), .bus_data_i(host_d), .bus_data_o(d_o), .bus_data_oe_o(d_oe),
        .a_port_pins_i(a_pins), .a_port_pins_o(a_po), .a_port_pins_oe_o(a_poe),
        .b_port_pins_i(b_pins), .b_port_pins_o(b_po), .b_port_pins_oe_o(b_poe),
        .a_edge_input_i(a_edge), .b_edge_input_i(b_edge), .a_control_line_i(a_line),
        .a_control_line_o(a_lo), .a_control_line_oe_o(a_loe), .b_control_line_i(b_line),
        .b_control_line_o(b_lo), .b_control_line_oe_o(b_loe), .a_interrupt_request_n_i(a_irq_n),
        .a_interrupt_request_n_o(), .a_interrupt_request_n_oe_o(a_iroe),
        .b_interrupt_request_n_i(b_irq_n), .b_interrupt_request_n_o(),
        .b_interrupt_request_n_oe_o(b_iroe));

    dppa_periph_model u_dppa_periph_model (.core_clk_i(clk), .load_i(load), .a_drv_i(a_po),
        .a_drv_oe_i(a_poe),
        .a_ext_i(a_ext), .a_pins_o(a_pins), .b_drv_i(b_po), .b_drv_oe_i(b_poe), .b_ext_i(b_ext),
        .b_pins_o(b_pins), .a_line_drv_i(a_lo), .a_line_oe_i(a_loe), .a_line_ext_i(a_line_ext),
        .a_line_o(a_line), .b_line_drv_i(b_lo), .b_line_oe_i(b_loe), .b_line_ext_i(b_line_ext),
        .b_line_o(b_line), .a_irq_oe_i(a_iroe), .b_irq_oe_i(b_iroe), .a_irq_n_o(a_irq_n),
        .b_irq_n_o(b_irq_n), .b_edge_req_i(b_edge_req), .b_edge_o(b_edge));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic wrap_up;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // the whole sequence needs well under 2000 cycles
    always @(negedge clk) begin
        cycles++;
        if (a_line === 1'b0) a_lows++;
        if (b_line === 1'b0) b_lows++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask

    // one processor cycle; on reads the host drives the inverse of its last data onto the bus
    task automatic acc(input logic r, input logic [1:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(negedge clk);
        rnw = r;
        {rs_hi, rs_lo} = a;
        host_d = r ? ~host_d : wd;
        cs1 = 1'b1;
        ph2 = 1'b1;
        repeat (4) @(negedge clk);
        rd = d_oe ? d_o : 8'hXX;
        ph2 = 1'b0;
        repeat (3) @(negedge clk);
        cs1 = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        acc(1'b0, a, d, junk);
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] got;
        acc(1'b1, a, 8'h00, got);
        chk(got, exp);
    endtask

    task automatic settle;
        repeat (5) @(negedge clk);
    endtask

    initial begin
        {rst_b, ph2, cs1, cs3_n, rs_hi, rs_lo, a_line_ext, b_line_ext} = 8'h00;
        {rnw, a_edge, b_edge_req} = 3'h7;
        host_d = 8'h00;
        load = 1'b0;
        a_ext = 8'h3C;
        b_ext = 8'hC3;
        {miscompares, n_compared, cycles, a_lows, b_lows} = '0;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        rd(C_A, 8'h00);
        rd(C_B, 8'h00);
        rd(P_A, 8'h00);
        rd(P_B, 8'h00);
        chk({a_irq_n, b_irq_n, a_loe, b_loe, 4'h0}, 8'hC0);
        cs3_n = 1'b1;
        wr(C_A, 8'h04);
        cs3_n = 1'b0;
        rd(C_A, 8'h00);
        wr(P_A, 8'hF0);
        wr(C_A, 8'h04);
        wr(P_A, 8'hA5);
        chk(a_poe, 8'hF0);
        rd(P_A, 8'hAC);
        wr(P_B, 8'h0F);
        wr(C_B, 8'h04);
        wr(P_B, 8'h5A);
        chk(b_poe, 8'h0F);
        rd(P_B, 8'hCA);
        load = 1'b1;
        settle();
        rd(P_A, 8'h2C);
        rd(P_B, 8'hCA);
        load = 1'b0;
        settle();
        wr(C_A, 8'h05);
        a_edge = 1'b0;
        settle();
        rd(C_A, 8'h85);
        chk1(a_irq_n, 1'b0);
        chk1(b_irq_n, 1'b1);
        rd(P_A, 8'hAC);
        rd(C_A, 8'h05);
        a_edge = 1'b1;
        settle();
        rd(C_A, 8'h05);
        wr(C_A, 8'h07);
        a_edge = 1'b0;
        settle();
        rd(C_A, 8'h07);
        a_edge = 1'b1;
        settle();
        rd(C_A, 8'h87);
        rd(P_A, 8'hAC);
        wr(C_A, 8'h1C);
        a_line_ext = 1'b1;
        settle();
        rd(C_A, 8'h5C);
        chk1(a_irq_n, 1'b0);
        rd(P_A, 8'hAC);
        rd(C_A, 8'h1C);
        wr(C_A, 8'h14);
        a_line_ext = 1'b0;
        settle();
        a_line_ext = 1'b1;
        settle();
        rd(C_A, 8'h54);
        chk1(a_irq_n, 1'b1);
        wr(C_A, 8'h2C);
        a_lows = 0;
        rd(P_A, 8'hAC);
        settle();
        chk(a_lows[7:0], 8'h01);
        wr(C_A, 8'h24);
        rd(P_A, 8'hAC);
        chk1(a_line, 1'b0);
        a_edge = 1'b0; // peripheral announces new data
        settle();
        chk1(a_line, 1'b1);
        a_edge = 1'b1;
        rd(P_A, 8'hAC);
        settle();
        chk1(a_line, 1'b0);
        wr(C_A, 8'h34);
        chk1(a_line, 1'b0);
        wr(C_A, 8'h3C);
        chk1(a_line, 1'b1);
        wr(C_B, 8'h05);
        b_edge_req = 1'b0;
        settle();
        rd(C_B, 8'h85);
        chk({a_irq_n, b_irq_n, 6'h00}, 8'h80);
        rd(P_B, 8'hCA);
        rd(C_B, 8'h05);
        b_edge_req = 1'b1;
        wr(C_B, 8'h1C);
        b_line_ext = 1'b1;
        settle();
        rd(C_B, 8'h5C);
        chk1(b_irq_n, 1'b0);
        rd(P_B, 8'hCA);
        wr(C_B, 8'h2C);
        b_lows = 0;
        rd(P_B, 8'hCA);
        settle();
        chk(b_lows[7:0], 8'h00);
        wr(P_B, 8'h66);
        settle();
        chk(b_lows[7:0], 8'h01);
        wr(C_B, 8'h24);
        b_lows = 0;
        wr(P_B, 8'h99);
        repeat (15) @(negedge clk);
        chk1(b_lows inside {[3:12]}, 1'b1);
        chk1(b_line, 1'b1);
        wrap_up();
    end
endmodule // dual_port_peripheral_adapter_tb_top
